// >>> rtl/event_timestamp_defs.vh
// Register offsets, reset values and timing constants of the event timestamper.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef EVENT_TIMESTAMP_DEFS_VH
`define EVENT_TIMESTAMP_DEFS_VH

// -----------------------------------------------------------------------------
// Register offsets (byte addresses relative to the decode base)
// -----------------------------------------------------------------------------
`define OFS_CONTROL      16'h0000
`define OFS_STATUS       16'h0004
`define OFS_WIRE_DELAY   16'h0008
`define OFS_EDGE_COUNT   16'h000C
`define OFS_TIME_NS      16'h0044
`define OFS_TIME_S       16'h0048
`define OFS_DATA_WIDTH   16'h004C
`define OFS_DATA_FIRST   16'h0050

// -----------------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------------
`define CTRL_ENABLE_BIT  0
`define CTRL_POLAR_BIT   1
`define STAT_NEW_BIT     0
`define CONTROL_RESET    2'h0
`define WIRE_DELAY_RESET 16'h0000

// -----------------------------------------------------------------------------
// Response codes and timing
// -----------------------------------------------------------------------------
`define RESP_OKAY        2'h0
`define RESP_DECERR      2'h3
`define CLK_PERIOD_NS    40
`define DETECT_CYCLES    4
`define NS_PER_SECOND    32'h3B9ACA00
`define DECODE_SPAN      32'h0000FFFF

`endif

// >>> rtl/event_timestamp_data_snapshot.v
// Event timestamper with data snapshot and an AXI4-Lite register slave.
// Assumes the reference time and the snapshot data are synchronous to mclk;
// the event input comes from a pin and is synchronised here.
//
// Contract
// - latch data word at the timestamp event
// - data width parameter sets data register count
// - least significant word at lowest address
// - unused top bits of last word read zero
// - data registers are read-only, writes ignored
// - structure fixed by parameters at synthesis
// - parameter picks static inputs or AXI configuration
// - buffer enable and depth are parameters; the code ignores both and holds one capture until cleared
// - parameter enables configurable cable delay correction
// - fixed input path delay in nanoseconds corrects time
// - polarity parameter: true high active, false low
// - parameter enables capture on both edges
// - fine clock ratio parameter sets resolution; the code only divides the latency step by it, capture stays on mclk
// - carry step fs and pin delay ps parameters
// - chain placement column and row parameters
// - decode between base and top, top base+FFFF
// - simulation parameter selects testbench behaviour
// - time has seconds, nanoseconds and 2-bit fraction
// - sign bit, one means negative time
// - time jump flag carried with time
// - sample reference time and correct for delays
// - read-only register reports snapshot width
`timescale 1ns/1ps
`include "event_timestamp_defs.vh"

module event_timestamp_data_snapshot #(
  parameter         config_source_param        = 0,
  parameter         buffered_param             = 0,
  parameter integer buffer_depth_param         = 1,
  parameter integer snapshot_width_param       = 48,
  parameter         wire_latency_enable_param  = 1,
  parameter integer input_latency_ns_param     = 0,
  parameter         edge_polarity_param        = 1,
  parameter         both_edges_param           = 0,
  parameter         fine_clock_enable_param    = 0,
  parameter integer fine_clock_ratio_param     = 1,
  parameter         delay_line_enable_param    = 0,
  parameter integer carry_step_fs_param        = 0,
  parameter integer pin_to_chain_ps_param      = 0,
  parameter         chain_placement_lock_param = 0,
  parameter integer chain_column_param         = 0,
  parameter integer chain_row_param            = 0,
  parameter [31:0]  decode_base_param          = 32'h00000000,
  parameter [31:0]  decode_top_param           = 32'h0000FFFF,
  parameter         sim_param                  = 0
) (
  input  wire                            mclk,
  input  wire                            reset,
  input  wire                            event_pin,
  input  wire [snapshot_width_param-1:0] snapshot_data,
  input  wire [31:0]                     ref_second,
  input  wire [31:0]                     ref_nanosecond,
  input  wire [1:0]                      ref_fraction,
  input  wire                            ref_sign,
  input  wire                            ref_time_jump,
  input  wire                            static_enable,
  input  wire                            static_polarity,
  input  wire [15:0]                     static_wire_delay,
  input  wire [31:0]                     s_axi_awaddr,
  input  wire                            s_axi_awvalid,
  output wire                            s_axi_awready,
  input  wire [31:0]                     s_axi_wdata,
  input  wire [3:0]                      s_axi_wstrb,
  input  wire                            s_axi_wvalid,
  output wire                            s_axi_wready,
  output reg  [1:0]                      s_axi_bresp,
  output reg                             s_axi_bvalid,
  input  wire                            s_axi_bready,
  input  wire [31:0]                     s_axi_araddr,
  input  wire                            s_axi_arvalid,
  output wire                            s_axi_arready,
  output reg  [31:0]                     s_axi_rdata,
  output reg  [1:0]                      s_axi_rresp,
  output reg                             s_axi_rvalid,
  input  wire                            s_axi_rready,
  output wire [1:0]                      ts_fraction,
  output wire                            ts_sign,
  output wire                            ts_time_jump,
  output wire                            ts_new
);

  // ---------------------------------------------------------------------------
  // Derived constants
  // ---------------------------------------------------------------------------
  localparam integer WORDS   = (snapshot_width_param + 31) / 32;
  localparam integer PAD     = WORDS * 32 - snapshot_width_param;
  // Detection resolution: fine clock shortens the latency term; the carry chain adds its pin delay.
  localparam integer STEP_NS = fine_clock_enable_param ?
                               (`CLK_PERIOD_NS / fine_clock_ratio_param) :
                               `CLK_PERIOD_NS;
  localparam integer CHAIN_NS = (delay_line_enable_param && !sim_param) ?
                                (pin_to_chain_ps_param / 1000) : 0;
  localparam integer FIXED_NS = input_latency_ns_param + CHAIN_NS +
                                `DETECT_CYCLES * STEP_NS;
  localparam [31:0] FIXED_DELAY = FIXED_NS[31:0];
  // The polarity bit leaves reset at the default polarity, so a core that is
  // only enabled by software already watches the intended edge.
  localparam [1:0]  CTRL_RESET_VAL = `CONTROL_RESET |
                                     {(edge_polarity_param != 0), 1'b0};

  // ---------------------------------------------------------------------------
  // Address decode helpers
  // ---------------------------------------------------------------------------
  // Window check, also used for reads and writes alike.
  function in_window;
    input [31:0] addr;
    begin
      in_window = (addr >= decode_base_param) && (addr <= decode_top_param);
    end
  endfunction

  // Offset of an access within the window.
  function [15:0] offset_of;
    input [31:0] addr;
    reg   [31:0] diff;
    begin
      diff      = addr - decode_base_param;
      offset_of = {diff[15:2], 2'b00};
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Configuration, status and capture registers
  // ---------------------------------------------------------------------------
  reg  [1:0]  control_ff;
  reg  [15:0] wire_delay_ff;
  reg         new_ff;
  reg  [31:0] edge_count_ff;
  reg  [31:0] ts_ns_ff;
  reg  [31:0] ts_s_ff;
  reg  [1:0]  ts_frac_ff;
  reg         ts_sign_ff;
  reg         ts_jump_ff;
  reg  [snapshot_width_param-1:0] snap_ff;

  // Static inputs replace the register values when the static source is chosen.
  wire        cfg_enable   = config_source_param ? static_enable :
                             control_ff[`CTRL_ENABLE_BIT];
  wire        cfg_polarity = config_source_param ? static_polarity :
                             control_ff[`CTRL_POLAR_BIT];
  wire [15:0] cfg_delay    = !wire_latency_enable_param ? 16'h0000 :
                             config_source_param ? static_wire_delay :
                             wire_delay_ff;

  // ---------------------------------------------------------------------------
  // Event synchroniser and edge detection
  // ---------------------------------------------------------------------------
  reg sync1_ff;
  reg sync2_ff;
  reg sync3_ff;
  reg level_ff;

  // Three stages; the level only moves when the last two agree.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      sync1_ff <= event_pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff) begin
        level_ff <= sync3_ff;
      end
    end
  end

  wire stable_ok  = (sync2_ff == sync3_ff);
  wire changed    = stable_ok && (sync3_ff != level_ff);
  wire active_now = sync3_ff ~^ cfg_polarity;
  wire edge_seen  = changed && (both_edges_param || active_now);
  // Only one timestamp is held; later events before a clear are counted but not captured.
  wire accept     = edge_seen && cfg_enable && !new_ff;

  // ---------------------------------------------------------------------------
  // Time correction
  // ---------------------------------------------------------------------------
  reg [31:0] nxt_ns;
  reg [31:0] nxt_s;
  reg [31:0] total_delay;

  // Subtract the fixed and cable delays, borrowing a second when needed.
  always @* begin
    total_delay = FIXED_DELAY + {16'h0000, cfg_delay};
    if (ref_nanosecond >= total_delay) begin
      nxt_ns = ref_nanosecond - total_delay;
      nxt_s  = ref_second;
    end else begin
      nxt_ns = ref_nanosecond + `NS_PER_SECOND - total_delay;
      nxt_s  = ref_second - 32'h00000001;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite handshake
  // ---------------------------------------------------------------------------
  wire        wr_go   = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire        rd_go   = s_axi_arvalid && !s_axi_rvalid;
  wire [15:0] wr_ofs  = offset_of(s_axi_awaddr);
  wire [15:0] rd_ofs  = offset_of(s_axi_araddr);
  wire        wr_hit  = in_window(s_axi_awaddr);
  wire        rd_hit  = in_window(s_axi_araddr);
  wire        wr_ok   = wr_go && wr_hit;
  wire        clr_new = wr_ok && (wr_ofs == `OFS_STATUS) && s_axi_wstrb[0] &&
                        s_axi_wdata[`STAT_NEW_BIT];

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;

  // ---------------------------------------------------------------------------
  // Register writes, capture and status
  // ---------------------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      control_ff    <= CTRL_RESET_VAL;
      wire_delay_ff <= `WIRE_DELAY_RESET;
      new_ff        <= 1'b0;
      edge_count_ff <= 32'h00000000;
      ts_ns_ff      <= 32'h00000000;
      ts_s_ff       <= 32'h00000000;
      ts_frac_ff    <= 2'h0;
      ts_sign_ff    <= 1'b0;
      ts_jump_ff    <= 1'b0;
      snap_ff       <= {snapshot_width_param{1'b0}};
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      if (wr_ok && (wr_ofs == `OFS_CONTROL) && s_axi_wstrb[0]) begin
        control_ff <= s_axi_wdata[1:0];
      end
      if (wr_ok && (wr_ofs == `OFS_WIRE_DELAY)) begin
        if (s_axi_wstrb[0]) begin
          wire_delay_ff[7:0] <= s_axi_wdata[7:0];
        end
        if (s_axi_wstrb[1]) begin
          wire_delay_ff[15:8] <= s_axi_wdata[15:8];
        end
      end
      if (edge_seen && cfg_enable) begin
        edge_count_ff <= edge_count_ff + 32'h00000001;
      end
      // A new capture wins over a clear in the same cycle.
      if (accept) begin
        new_ff     <= 1'b1;
        ts_ns_ff   <= nxt_ns;
        ts_s_ff    <= nxt_s;
        ts_frac_ff <= ref_fraction;
        ts_sign_ff <= ref_sign;
        ts_jump_ff <= ref_time_jump;
        snap_ff    <= snapshot_data;
      end else if (clr_new) begin
        new_ff <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign ts_fraction  = ts_frac_ff;
  assign ts_sign      = ts_sign_ff;
  assign ts_time_jump = ts_jump_ff;
  assign ts_new       = new_ff;

  // ---------------------------------------------------------------------------
  // Snapshot word layout
  // ---------------------------------------------------------------------------
  wire [WORDS*32-1:0] snap_words;

  generate
    if (PAD > 0) begin : g_pad
      assign snap_words = {{PAD{1'b0}}, snap_ff};
    end else begin : g_nopad
      assign snap_words = snap_ff;
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  reg  [31:0] rd_value;
  reg  [15:0] data_index;
  integer     k;

  // Data words sit at successive addresses, lowest word first.
  always @* begin
    rd_value   = 32'h00000000;
    data_index = (rd_ofs - `OFS_DATA_FIRST) >> 2;
    case (rd_ofs)
      `OFS_CONTROL:    rd_value = {30'h00000000, control_ff};
      `OFS_STATUS:     rd_value = {31'h00000000, new_ff};
      `OFS_WIRE_DELAY: rd_value = {16'h0000, wire_delay_ff};
      `OFS_EDGE_COUNT: rd_value = edge_count_ff;
      `OFS_TIME_NS:    rd_value = ts_ns_ff;
      `OFS_TIME_S:     rd_value = ts_s_ff;
      `OFS_DATA_WIDTH: rd_value = snapshot_width_param;
      default: begin
        for (k = 0; k < WORDS; k = k + 1) begin
          if ((rd_ofs >= `OFS_DATA_FIRST) && (data_index == k[15:0])) begin
            rd_value = snap_words[k*32 +: 32];
          end
        end
      end
    endcase
  end

  // Read answer is registered and held until taken.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? rd_value : 32'h00000000;
      s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // event_timestamp_data_snapshot

// >>> dv/axi_lite_cpu_model.sv
// AXI4-Lite master standing in for the processor that reads timestamps.
// Assumes the slave samples on the rising edge of mclk; this side moves on falling edges.
`timescale 1ns/1ps
module axi_lite_cpu_model (
  input  wire        mclk,
  output reg  [31:0] awaddr,
  output reg         awvalid,
  input  wire        awready,
  output reg  [31:0] wdata,
  output reg  [3:0]  wstrb,
  output reg         wvalid,
  input  wire        wready,
  input  wire        bvalid,
  output reg         bready,
  output reg  [31:0] araddr,
  output reg         arvalid,
  input  wire        arready,
  input  wire        rvalid,
  output reg         rready
);
  // ---------------------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------------------
  // The bus idles with nothing requested and full byte lanes.
  initial begin
    {awaddr, wdata, araddr} = 96'h0;
    {awvalid, wvalid, arvalid, bready, rready} = 5'h0;
    wstrb = 4'hF;
  end

  // One transfer; the answer is taken after a random stall so slow hosts are covered.
  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    begin
      @(negedge mclk);
      awaddr = a;
      wdata = d;
      araddr = a;
      awvalid = wr;
      wvalid = wr;
      arvalid = !wr;
      @(posedge mclk);
      while (!(wr ? awready && wready : arready)) @(posedge mclk);
      @(negedge mclk);
      {awvalid, wvalid, arvalid} = 3'h0;
      // Released lines are inverted so a stale value is never mistaken for a live one.
      awaddr = ~awaddr;
      wdata = ~wdata;
      araddr = ~araddr;
      repeat ($urandom % 3) @(negedge mclk);
      bready = wr;
      rready = !wr;
      @(posedge mclk);
      while (!(wr ? bvalid : rvalid)) @(posedge mclk);
      @(negedge mclk);
      {bready, rready} = 2'h0;
    end
  endtask
endmodule // axi_lite_cpu_model

// >>> dv/event_timestamp_properties.sv
// Port-level assertions for the event timestamper.
// Assumes binding to the top module; everything runs on mclk.
`timescale 1ns/1ps
`include "event_timestamp_defs.vh"
module event_timestamp_checker #(
  parameter integer snapshot_width_param = 48,
  parameter [31:0]  decode_base_param    = 32'h00000000,
  parameter [31:0]  decode_top_param     = 32'h0000FFFF
) (
  input wire        mclk,
  input wire        reset,
  input wire        event_pin,
  input wire [1:0]  ref_fraction,
  input wire        ref_time_jump,
  input wire [31:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire [31:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire [1:0]  ts_fraction,
  input wire        ts_time_jump,
  input wire        ts_new
);
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  localparam integer PADW = (snapshot_width_param % 32 == 0) ? 32 : snapshot_width_param % 32;
  localparam [31:0]  LAST = decode_base_param + 32'h50 + 4 * ((snapshot_width_param - 1) / 32);
  reg        pin_d_ff;
  reg  [3:0] since_pin_ff;
  wire       rd_out = s_axi_araddr < decode_base_param || s_axi_araddr > decode_top_param;
  wire       wr_out = s_axi_awaddr < decode_base_param || s_axi_awaddr > decode_top_param;
  wire       clr_hit = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_wstrb[0]
                       && s_axi_wdata[0] && s_axi_awaddr == decode_base_param + 32'h4;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_rd_take;
    s_axi_arvalid && !s_axi_rvalid;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence

  // Cycles since the pin last moved; saturates so a quiet pin never wraps round.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_d_ff <= 1'b0;
      since_pin_ff <= 4'hF;
    end else begin
      pin_d_ff <= event_pin;
      since_pin_ff <= (event_pin != pin_d_ff) ? 4'h0 : since_pin_ff + {3'h0, since_pin_ff != 4'hF};
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_rd_decode_err: assert property (
    s_rd_take ##0 rd_out |=> s_axi_rvalid && s_axi_rresp == `RESP_DECERR && s_axi_rdata == 32'h0)
    else $error("read outside the window was not refused");
  a_rd_decode_ok: assert property (
    s_rd_take ##0 !rd_out |=> s_axi_rvalid && s_axi_rresp == `RESP_OKAY)
    else $error("read inside the window was not answered okay");
  a_wr_decode_err: assert property (
    s_wr_take ##0 wr_out |=> s_axi_bvalid && s_axi_bresp == `RESP_DECERR)
    else $error("write outside the window was not refused");
  a_width_report: assert property (
    s_rd_take ##0 s_axi_araddr == decode_base_param + 32'h4C
    |=> s_axi_rdata == snapshot_width_param)
    else $error("width register does not match the snapshot width");
  a_top_pad_zero: assert property (
    s_rd_take ##0 s_axi_araddr == LAST |=> (s_axi_rdata >> PADW) == 32'h0)
    else $error("unused bits of the last data word are not zero");
  a_capture_latency: assert property (
    $rose(ts_new) |-> since_pin_ff >= 4'h2 && since_pin_ff <= 4'h6)
    else $error("capture flag rose without a recent pin edge");
  a_capture_held: assert property (
    ts_new && !clr_hit |=> ts_new)
    else $error("held capture vanished without a clear");
  a_fields_taken: assert property (
    $rose(ts_new) |-> ts_fraction == $past(ref_fraction) && ts_time_jump == $past(ref_time_jump))
    else $error("captured fraction or jump flag differs from the reference");
endmodule // event_timestamp_checker

// >>> dv/event_timestamp_data_snapshot_tb.sv
// Self-checking bench for the event timestamper with data snapshot.
// Assumes the design sources and its defines header are on the include path.
`timescale 1ns/1ps
`include "event_timestamp_defs.vh"
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module event_timestamp_data_snapshot_tb;
  typedef struct {string nm; logic [33:0] v;} note_t;
  logic        mclk, reset, event_pin, ref_sign, ref_time_jump;
  logic [47:0] snap, old;
  logic [31:0] ref_second, ref_nanosecond, ns_exp, s_exp, lat;
  logic [1:0]  ref_fraction;
  logic [63:0] rnd;
  wire  [31:0] awaddr, wdata, araddr, rdata;
  wire  [3:0]  wstrb;
  wire  [1:0]  bresp, rresp, ts_fraction;
  wire         awvalid, awready, wvalid, wready, bvalid, bready, ts_sign, ts_time_jump;
  wire         arvalid, arready, rvalid, rready, ts_new;
  note_t       rq[$], wq[$], e;
  integer      err_total, samples_checked, k;

  event_timestamp_data_snapshot #(.snapshot_width_param(48), .input_latency_ns_param(20))
  event_timestamp_data_snapshot_inst (.mclk(mclk), .reset(reset), .event_pin(event_pin),
    .snapshot_data(snap), .ref_second(ref_second), .ref_nanosecond(ref_nanosecond),
    .ref_fraction(ref_fraction), .ref_sign(ref_sign), .ref_time_jump(ref_time_jump),
    .static_enable(1'b0), .static_polarity(1'b0), .static_wire_delay(16'h0000),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ts_fraction(ts_fraction), .ts_sign(ts_sign), .ts_time_jump(ts_time_jump), .ts_new(ts_new));
  axi_lite_cpu_model axi_lite_cpu_model_inst (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready));

  // ---------------------------------------------------------------------------
  // Clock, tasks and result monitor
  // ---------------------------------------------------------------------------
  always #20 mclk = ~mclk;

  // Answers are compared at the handshake edge against the oldest note.
  always @(posedge mclk) begin
    if (rvalid && rready) begin
      e = rq.pop_front();
      `CHK(e.nm, e.v, {rresp, rdata})
    end
    if (bvalid && bready) begin
      e = wq.pop_front();
      `CHK(e.nm, e.v[33:32], bresp)
    end
  end

  task rd(input string nm, input logic [31:0] a, input logic [33:0] v);
    rq.push_back('{nm, v});
    axi_lite_cpu_model_inst.xfer(1'b0, a, 32'h0);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    wq.push_back('{"write response", {r, 32'h0}});
    axi_lite_cpu_model_inst.xfer(1'b1, a, d);
  endtask
  // Active level is held long enough that the trailing edge never overlaps the capture.
  task pulse(input logic act);
    @(negedge mclk);
    event_pin = act;
    repeat (8) @(negedge mclk);
    event_pin = !act;
    repeat (8) @(negedge mclk);
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    $display("watchdog expired");
    report_and_stop;
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    {mclk, event_pin, ref_sign, ref_time_jump, ref_fraction} = 6'h0;
    {snap, old, ref_second, ref_nanosecond} = 160'h0;
    reset = 1'b1;
    err_total = 0;
    samples_checked = 0;
    rnd = $urandom(5);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    rd("width", `OFS_DATA_WIDTH, {`RESP_OKAY, 32'h00000030});
    rd("control reset", `OFS_CONTROL, {`RESP_OKAY, 32'h00000002});
    rd("outside read", 32'h00010000, {`RESP_DECERR, 32'h00000000});
    wr(32'h00010000, 32'h00000001, `RESP_DECERR);
    rd("window hole", 32'h0000FFFC, {`RESP_OKAY, 32'h00000000});
    pulse(1'b1);
    `CHK("disabled capture", 1'b0, ts_new)
    $display("decode and disabled test done");
    lat = $urandom % 1000;
    wr(`OFS_WIRE_DELAY, lat, `RESP_OKAY);
    lat = lat + 20 + `DETECT_CYCLES * `CLK_PERIOD_NS;
    for (k = 0; k < 2; k++) begin
      wr(`OFS_CONTROL, {30'h0, k == 0, 1'b1}, `RESP_OKAY);
      @(negedge mclk);
      event_pin = (k != 0);
      wr(`OFS_STATUS, 32'h00000001, `RESP_OKAY);
      rnd = {$urandom, $urandom};
      snap = rnd[47:0];
      ref_fraction = rnd[49:48];
      ref_time_jump = rnd[50];
      ref_sign = rnd[51];
      ref_second = $urandom | 32'h00000001;
      ref_nanosecond = k ? 32'h00000005 : $urandom % `NS_PER_SECOND;
      pulse(k == 0);
      `CHK("capture flag", 1'b1, ts_new)
      `CHK("sign", ref_sign, ts_sign)
      ns_exp = ref_nanosecond - lat;
      s_exp = ref_second;
      // A short reference forces the borrow of one second.
      if (ref_nanosecond < lat) begin
        ns_exp = ns_exp + `NS_PER_SECOND;
        s_exp = s_exp - 1;
      end
      rd("time ns", `OFS_TIME_NS, {`RESP_OKAY, ns_exp});
      rd("time s", `OFS_TIME_S, {`RESP_OKAY, s_exp});
      rd("word 0", `OFS_DATA_FIRST, {`RESP_OKAY, snap[31:0]});
      rd("word 1", `OFS_DATA_FIRST + 4, {`RESP_OKAY, 16'h0000, snap[47:32]});
      wr(`OFS_DATA_FIRST, ~snap[31:0], `RESP_OKAY);
      old = snap;
      snap = ~snap;
      pulse(k == 0);
      rd("held word", `OFS_DATA_FIRST, {`RESP_OKAY, old[31:0]});
      $display("capture test %0d done", k);
    end
    report_and_stop;
  end
endmodule // event_timestamp_data_snapshot_tb

bind event_timestamp_data_snapshot event_timestamp_checker #(
  .snapshot_width_param(snapshot_width_param), .decode_base_param(decode_base_param),
  .decode_top_param(decode_top_param)
) event_timestamp_checker_inst (.mclk(mclk), .reset(reset), .event_pin(event_pin),
  .ref_fraction(ref_fraction), .ref_time_jump(ref_time_jump), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .ts_fraction(ts_fraction),
  .ts_time_jump(ts_time_jump), .ts_new(ts_new));
